// *** verilog/pme_wake_defs.svh ***
`ifndef PME_WAKE_DEFS_SVH
`define PME_WAKE_DEFS_SVH

// ****************************************
// register indices (byte address = 4 x index)
// ****************************************
`define IDX_WAKE_OPTIONS 8'he7
`define IDX_RSVD_E8 8'he8
`define IDX_RSVD_E9 8'he9
`define IDX_KEY_INDEX 8'he1
`define IDX_KEY_DATA 8'he2
`define IDX_GLOBAL_EN 8'hf2
`define IDX_STATUS_LOW 8'hf3
`define IDX_STATUS_HIGH 8'hf4
`define IDX_ENABLE_LOW 8'hf6
`define IDX_ENABLE_HIGH 8'hf7
`define IDX_GPIO_ROUTE 8'hfe

// ****************************************
// field positions
// ****************************************
`define WO_KEY_SET_THREE 7
`define WO_KEY_SET_TWO 6
`define WO_OS_WAKE_KEY 5
`define WO_PLOSS_PULSE 4
`define WO_WDT_RST_SEL 3
`define WO_HWM_RST_SEL 0
`define WO_WRITE_MASK 8'hf9
`define ROUTE_WRITE_MASK 8'hf7
`define STS_LOW_MASK 7'h7f
`define STS_HIGH_MASK 6'h3f

// ****************************************
// reset values
// ****************************************
`define WAKE_OPTIONS_RST 8'h00
`define GLOBAL_EN_RST 8'h3e
`define STATUS_RST 8'h00
`define ENABLE_RST 8'h00
`define ROUTE_RST 8'h00

// ****************************************
// key table windows and timing
// ****************************************
`define KEY_SET_TWO_HI 4'h3
`define KEY_SET_THREE_HI 4'h4
`define KEY_LAST_LO 4'hf
`define CLK_KHZ 25000
`define PLOSS_LEVEL_MS 500
`define WAKE_PULSE_CYCLES 16

`endif

// *** verilog/pme_wake_pkg.sv ***
`default_nettype none
package pme_wake_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_CMP, KEY_PEEK} key_state_e;

  typedef struct packed {
    logic [7:0] wake;
    logic gen_en;
    logic [6:0] sts_lo;
    logic [5:0] sts_hi;
    logic [6:0] en_lo;
    logic [5:0] en_hi;
    logic [7:0] route;
    logic [7:0] key_index;
    logic bus_rst_s1, bus_rst_s2;
    logic pgood_s1, pgood_s2;
    logic [2:0] gpio_s1, gpio_s2;
    logic restore_s1, restore_s2, restore_d;
    logic pme_n, ps_n, wdt_rst_n, hwm_rst_n;
    logic aw_got, w_got;
    logic [7:0] aw_idx;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_wait, rvalid;
    logic [7:0] rd_idx;
    logic [7:0] rdata;
    logic [1:0] rresp;
    key_state_e kst;
    logic set_sel;
    logic [7:0] code;
    logic [3:0] ptr2, ptr3;
    logic [31:0] ps_cnt;
  } state_s;

  typedef struct packed {
    logic [31:0][7:0] mem;
    logic [7:0] a_rdata;
    logic [7:0] b_rdata;
  } table_s;

endpackage
`default_nettype wire

// *** verilog/key_table_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// key combination table, two read ports
// ****************************************
module key_table_mem (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [4:0] a_addr_i,
  output logic [7:0] a_rdata_o,
  input wire logic [4:0] b_addr_i,
  output logic [7:0] b_rdata_o
);

  pme_wake_pkg::table_s r;
  pme_wake_pkg::table_s n;

  always_comb begin
    n = r;
    if (we_i) begin
      n.mem[waddr_i] = wdata_i;
    end
    n.a_rdata = r.mem[a_addr_i];
    n.b_rdata = r.mem[b_addr_i];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign a_rdata_o = r.a_rdata;
  assign b_rdata_o = r.b_rdata;

endmodule // key_table_mem

`default_nettype wire

// *** verilog/pme_wake_event_control.sv ***
// Behaviour
// - key set three enable adds a wake match on table indices 40h..4eh.
// - key set two enable adds a wake match on 30h..3eh, else ignored.
// - os wake key enable lets the dedicated key drive the power switch.
// - pulse enable gives a 0.5s power switch level on power restore when the power loss policy selects on.
// - policy 00 off, 01 on, 10 prior state, 11 user last-state flag.
// - bit 3 picks watchdog reset: 0 bus reset, 1 power good.
// - bit 0 picks monitor reset: 0 power good, 1 bus reset.
// - wake option bits survive bus reset and power good loss.
// - global event enable bit 0 gates status events to the event output (gpio routes bypass it), reset 3eh.
// - low status latches seven device events on bits 6..0.
// - high status latches six events on bits 5..0.
// - status bits stay set until a 1 is written to that bit.
// - low enable register masks low status bits one to one.
// - high enable register masks high status bits one to one.
// - route bits 6..4 send gpio events c, b, a to the power switch.
// - route bits 2..0 send gpio events c, b, a to the event output.
`timescale 1ns/1ps
`include "pme_wake_defs.svh"
`default_nettype none

module pme_wake_event_control #(
  parameter int unsigned LEVEL_CYCLES = `PLOSS_LEVEL_MS * `CLK_KHZ,
  parameter int unsigned PULSE_CYCLES = `WAKE_PULSE_CYCLES,
  parameter logic [7:0] OS_KEY_CODE = 8'h5b
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // axi4-lite slave
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [11:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [11:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // event sources, same clock
  input wire logic uart_c_irq_i,
  input wire logic mouse_irq_i,
  input wire logic keyboard_controller_irq_i,
  input wire logic parallel_port_irq_i,
  input wire logic floppy_controller_irq_i,
  input wire logic uart_a_irq_i,
  input wire logic uart_b_irq_i,
  input wire logic uart_f_irq_i,
  input wire logic uart_e_irq_i,
  input wire logic hw_monitor_irq_i,
  input wire logic watchdog_timeout_i,
  input wire logic uart_d_irq_i,
  input wire logic ring_indicate_b_i,
  // keyboard wake stream, same clock
  input wire logic kb_wake_enable_i,
  input wire logic kb_code_valid_i,
  input wire logic [7:0] kb_code_i,
  // power loss policy, same clock
  input wire logic [1:0] power_loss_policy_i,
  input wire logic last_state_off_i,
  input wire logic prior_state_on_i,
  // pins
  input wire logic power_restored_i,
  input wire logic bus_reset_input_n_i,
  input wire logic power_good_i,
  input wire logic gpio_event_a_i,
  input wire logic gpio_event_b_i,
  input wire logic gpio_event_c_i,
  output logic pme_n_o,
  output logic power_switch_output_n_o,
  output logic watchdog_reset_n_o,
  output logic hw_monitor_reset_n_o
);

  pme_wake_pkg::state_s r;
  pme_wake_pkg::state_s n;
  logic [7:0] key_a_rd;
  logic [7:0] key_b_rd;
  logic [4:0] key_b_addr;
  logic key_we;
  logic [4:0] key_waddr;
  localparam logic [7:0] GEN_EN_RST = `GLOBAL_EN_RST;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic slot_ok(input logic [7:0] idx);
    slot_ok = (idx[7:4] == `KEY_SET_TWO_HI ||
               idx[7:4] == `KEY_SET_THREE_HI) &&
              idx[3:0] != `KEY_LAST_LO;
  endfunction

  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    slot_of = {idx[7:4] == `KEY_SET_THREE_HI, idx[3:0]};
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    unique case (idx)
      `IDX_WAKE_OPTIONS, `IDX_RSVD_E8, `IDX_RSVD_E9, `IDX_KEY_INDEX,
      `IDX_KEY_DATA, `IDX_GLOBAL_EN, `IDX_STATUS_LOW, `IDX_STATUS_HIGH,
      `IDX_ENABLE_LOW, `IDX_ENABLE_HIGH, `IDX_GPIO_ROUTE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ****************************************
  // key combination table
  // ****************************************
  key_table_mem u_key_table (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .we_i(key_we),
    .waddr_i(key_waddr),
    .wdata_i(r.wdata),
    .a_addr_i(slot_of(r.key_index)),
    .a_rdata_o(key_a_rd),
    .b_addr_i(key_b_addr),
    .b_rdata_o(key_b_rd)
  );

  assign key_waddr = slot_of(r.key_index);
  assign key_we = r.aw_got && r.w_got && !r.bvalid && r.wstrb0 &&
                  r.aw_idx == `IDX_KEY_DATA && slot_ok(r.key_index);
  assign key_b_addr = {n.set_sel, n.set_sel ? n.ptr3 : n.ptr2};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic do_write;
    logic [7:0] wd;
    logic [6:0] clr_lo;
    logic [5:0] clr_hi;
    logic [6:0] ev_lo;
    logic [5:0] ev_hi;
    logic set_en;
    logic [3:0] ptr;
    logic wake_fire;
    logic want_on;
    logic restore_edge;
    do_write = r.aw_got && r.w_got && !r.bvalid;
    wd = r.wdata;
    clr_lo = '0;
    clr_hi = '0;
    wake_fire = 1'b0;
    want_on = 1'b0;
    set_en = 1'b0;
    ptr = 4'h0;
    ev_lo = '0;
    ev_hi = '0;
    restore_edge = 1'b0;
    n = r;

    // pin synchronisers
    n.bus_rst_s1 = bus_reset_input_n_i;
    n.bus_rst_s2 = r.bus_rst_s1;
    n.pgood_s1 = power_good_i;
    n.pgood_s2 = r.pgood_s1;
    n.gpio_s1 = {gpio_event_c_i, gpio_event_b_i, gpio_event_a_i};
    n.gpio_s2 = r.gpio_s1;
    n.restore_s1 = power_restored_i;
    n.restore_s2 = r.restore_s1;
    n.restore_d = r.restore_s2;
    restore_edge = r.restore_s2 && !r.restore_d;

    // write channel
    if (awvalid_i && awready_o) begin
      n.aw_got = 1'b1;
      n.aw_idx = awaddr_i[9:2];
    end
    if (wvalid_i && wready_o) begin
      n.w_got = 1'b1;
      n.wdata = wdata_i[7:0];
      n.wstrb0 = wstrb_i[0];
    end
    if (do_write) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(r.aw_idx) ? 2'h0 : 2'h2;
      if (r.wstrb0) begin
        unique case (r.aw_idx)
          `IDX_WAKE_OPTIONS: n.wake = wd & `WO_WRITE_MASK;
          `IDX_KEY_INDEX: n.key_index = wd;
          `IDX_GLOBAL_EN: n.gen_en = wd[0];
          `IDX_STATUS_LOW: clr_lo = wd[6:0];
          `IDX_STATUS_HIGH: clr_hi = wd[5:0];
          `IDX_ENABLE_LOW: n.en_lo = wd[6:0];
          `IDX_ENABLE_HIGH: n.en_hi = wd[5:0];
          `IDX_GPIO_ROUTE: n.route = wd & `ROUTE_WRITE_MASK;
          default: ;
        endcase
      end
    end
    if (r.bvalid && bready_i) begin
      n.bvalid = 1'b0;
    end

    // read channel
    if (arvalid_i && arready_o) begin
      n.rd_wait = 1'b1;
      n.rd_idx = araddr_i[9:2];
    end
    if (r.rd_wait) begin
      n.rd_wait = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = mapped(r.rd_idx) ? 2'h0 : 2'h2;
      unique case (r.rd_idx)
        `IDX_WAKE_OPTIONS: n.rdata = r.wake;
        `IDX_KEY_INDEX: n.rdata = r.key_index;
        `IDX_KEY_DATA: n.rdata = slot_ok(r.key_index) ? key_a_rd : 8'h00;
        `IDX_GLOBAL_EN: n.rdata = {GEN_EN_RST[7:1], r.gen_en};
        `IDX_STATUS_LOW: n.rdata = {1'b0, r.sts_lo};
        `IDX_STATUS_HIGH: n.rdata = {2'h0, r.sts_hi};
        `IDX_ENABLE_LOW: n.rdata = {1'b0, r.en_lo};
        `IDX_ENABLE_HIGH: n.rdata = {2'h0, r.en_hi};
        `IDX_GPIO_ROUTE: n.rdata = r.route;
        default: n.rdata = 8'h00;
      endcase
    end
    if (r.rvalid && rready_i) begin
      n.rvalid = 1'b0;
    end

    // status latches, a new event beats a same-cycle clear
    ev_lo = {uart_c_irq_i, mouse_irq_i, keyboard_controller_irq_i,
             parallel_port_irq_i, floppy_controller_irq_i,
             uart_a_irq_i, uart_b_irq_i};
    ev_hi = {uart_f_irq_i, uart_e_irq_i, hw_monitor_irq_i,
             watchdog_timeout_i, uart_d_irq_i,
             ring_indicate_b_i};
    n.sts_lo = ((r.sts_lo & ~clr_lo) | ev_lo) & `STS_LOW_MASK;
    n.sts_hi = ((r.sts_hi & ~clr_hi) | ev_hi) & `STS_HIGH_MASK;

    // keyboard combination matcher
    ptr = r.set_sel ? r.ptr3 : r.ptr2;
    set_en = r.set_sel ? r.wake[`WO_KEY_SET_THREE]
                       : r.wake[`WO_KEY_SET_TWO];
    unique case (r.kst)
      pme_wake_pkg::KEY_IDLE: begin
        if (kb_code_valid_i && kb_wake_enable_i) begin
          n.code = kb_code_i;
          n.set_sel = 1'b0;
          n.kst = pme_wake_pkg::KEY_CMP;
          if (kb_code_i == OS_KEY_CODE && r.wake[`WO_OS_WAKE_KEY]) begin
            wake_fire = 1'b1;
          end
        end
      end
      pme_wake_pkg::KEY_CMP: begin
        if (set_en && key_b_rd == r.code && key_b_rd != 8'h00) begin
          ptr = ptr + 4'h1;
          n.kst = pme_wake_pkg::KEY_PEEK;
        end else begin
          ptr = 4'h0;
          n.kst = r.set_sel ? pme_wake_pkg::KEY_IDLE
                            : pme_wake_pkg::KEY_CMP;
          n.set_sel = 1'b1;
        end
      end
      pme_wake_pkg::KEY_PEEK: begin
        if (key_b_rd == 8'h00) begin
          wake_fire = 1'b1;
          ptr = 4'h0;
        end
        n.kst = r.set_sel ? pme_wake_pkg::KEY_IDLE
                          : pme_wake_pkg::KEY_CMP;
        n.set_sel = 1'b1;
      end
    endcase
    if (r.set_sel) begin
      n.ptr3 = ptr;
    end else begin
      n.ptr2 = ptr;
    end
    if (r.kst == pme_wake_pkg::KEY_PEEK && !r.set_sel) begin
      n.set_sel = 1'b1;
    end
    if (r.kst != pme_wake_pkg::KEY_IDLE && !kb_wake_enable_i) begin
      n.kst = pme_wake_pkg::KEY_IDLE;
    end

    // power switch timing
    unique case (power_loss_policy_i)
      2'h0: want_on = 1'b0;
      2'h1: want_on = 1'b1;
      2'h2: want_on = prior_state_on_i;
      2'h3: want_on = !last_state_off_i;
    endcase
    if (r.ps_cnt != 32'h0) begin
      n.ps_cnt = r.ps_cnt - 32'h1;
    end
    if (restore_edge && want_on && r.wake[`WO_PLOSS_PULSE]) begin
      n.ps_cnt = LEVEL_CYCLES;
    end else if (wake_fire && r.ps_cnt == 32'h0) begin
      n.ps_cnt = PULSE_CYCLES;
    end

    // registered outputs
    n.ps_n = !(r.ps_cnt != 32'h0 ||
               |(r.gpio_s2 & r.route[6:4]));
    n.pme_n = !((r.gen_en && (|(r.sts_lo & r.en_lo) ||
                              |(r.sts_hi & r.en_hi))) ||
                |(r.gpio_s2 & r.route[2:0]));
    n.wdt_rst_n = r.wake[`WO_WDT_RST_SEL] ? r.pgood_s2
                                          : r.bus_rst_s2;
    n.hwm_rst_n = r.wake[`WO_HWM_RST_SEL] ? r.bus_rst_s2
                                          : r.pgood_s2;
  end

  // ****************************************
  // state register
  // ****************************************
  // standby reset only: bus reset and power good never clear options
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.wake <= `WAKE_OPTIONS_RST;
      r.gen_en <= GEN_EN_RST[0];
      r.sts_lo <= 7'(`STATUS_RST);
      r.sts_hi <= 6'(`STATUS_RST);
      r.en_lo <= 7'(`ENABLE_RST);
      r.en_hi <= 6'(`ENABLE_RST);
      r.route <= `ROUTE_RST;
      r.kst <= pme_wake_pkg::KEY_IDLE;
      r.pme_n <= 1'b1;
      r.ps_n <= 1'b1;
      r.wdt_rst_n <= 1'b0;
      r.hwm_rst_n <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign awready_o = !r.aw_got && !r.bvalid;
  assign wready_o = !r.w_got && !r.bvalid;
  assign bvalid_o = r.bvalid;
  assign bresp_o = r.bresp;
  assign arready_o = !r.rvalid && !r.rd_wait;
  assign rvalid_o = r.rvalid;
  assign rdata_o = {24'h0, r.rdata};
  assign rresp_o = r.rresp;
  assign pme_n_o = r.pme_n;
  assign power_switch_output_n_o = r.ps_n;
  assign watchdog_reset_n_o = r.wdt_rst_n;
  assign hw_monitor_reset_n_o = r.hwm_rst_n;

endmodule // pme_wake_event_control

`default_nettype wire

// *** dv/pme_wake_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module pme_wake_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic bus_reset_input_n_i,
  input wire logic power_good_i,
  input wire logic watchdog_reset_n_o,
  input wire logic hw_monitor_reset_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  b_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o)
    else $error("bvalid dropped early");
  r_hold_a: assert property (rvalid_o && !rready_i
    |=> rvalid_o && $stable(rdata_o))
    else $error("read answer not held");
  r_upper_a: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0)
    else $error("read upper bits set");
  w_answer_a: assert property (awvalid_i && awready_o && wvalid_i
    && wready_o |=> !bvalid_o ##1 bvalid_o)
    else $error("write answer late");
  r_answer_a: assert property (arvalid_i && arready_o
    |=> !rvalid_o ##1 rvalid_o)
    else $error("read answer timing");
  aw_block_a: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write taken during answer");
  wdt_low_a: assert property (
    (!bus_reset_input_n_i && !power_good_i) [*4]
    |=> !watchdog_reset_n_o)
    else $error("watchdog reset missed");
  hwm_low_a: assert property (
    (!bus_reset_input_n_i && !power_good_i) [*4]
    |=> !hw_monitor_reset_n_o)
    else $error("monitor reset missed");
  rst_free_a: assert property (
    (bus_reset_input_n_i && power_good_i) [*4]
    |=> watchdog_reset_n_o && hw_monitor_reset_n_o)
    else $error("reset output stuck");
  cover property (awvalid_i && awready_o && wvalid_i && wready_o);
  cover property (arvalid_i && arready_o);
  cover property (!watchdog_reset_n_o && hw_monitor_reset_n_o);
endmodule // pme_wake_props
bind pme_wake_event_control pme_wake_props i_props (.*);
`default_nettype wire

// *** dv/pme_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// host side, power switch pulse meter
// ****
module pme_host_model (
  input wire logic clk_i,
  input wire logic ps_n_i,
  output int cnt_o,
  output int width_o
);
  int run = 0;
  int cnt = 0;
  int wid = 0;
  assign cnt_o = cnt;
  assign width_o = wid;
  always @(posedge clk_i) begin
    if (!ps_n_i) begin
      run <= run + 1;
    end else if (run != 0) begin
      wid <= run;
      cnt <= cnt + 1;
      run <= 0;
    end
  end
endmodule // pme_host_model
`default_nettype wire

// *** dv/pme_wake_event_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module pme_wake_event_control_tb;
  localparam int LVL = 50;
  localparam int PUL = 16;
  logic clk_i, nrst_i, awvalid_i, awready_o, wvalid_i, wready_o;
  logic bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
  logic [11:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0] wstrb_i;
  logic [1:0] bresp_o, rresp_o, power_loss_policy_i, rd_r;
  logic uart_c_irq_i, mouse_irq_i, keyboard_controller_irq_i;
  logic parallel_port_irq_i, floppy_controller_irq_i, uart_a_irq_i;
  logic uart_b_irq_i, uart_f_irq_i, uart_e_irq_i, hw_monitor_irq_i;
  logic watchdog_timeout_i, uart_d_irq_i, ring_indicate_b_i;
  logic kb_wake_enable_i, kb_code_valid_i, last_state_off_i;
  logic prior_state_on_i, power_restored_i, bus_reset_input_n_i;
  logic power_good_i, gpio_event_a_i, gpio_event_b_i, gpio_event_c_i;
  logic pme_n_o, power_switch_output_n_o, watchdog_reset_n_o;
  logic hw_monitor_reset_n_o;
  logic [7:0] kb_code_i, rd_d, a, d, m8;
  logic [12:0] src, v, sl;
  logic [15:0] m;
  logic [4:0] pc;
  logic [2:0] gp;
  int failures = 0, samples_checked = 0, p_cnt, p_w, i, c0;
  logic [7:0] ri [9] = '{8'he7, 8'he8, 8'he9, 8'hf2, 8'hf3, 8'hf4,
    8'hf6, 8'hf7, 8'hfe};
  logic [7:0] wi [5] = '{8'he7, 8'hf2, 8'hf6, 8'hf7, 8'hfe};
  logic [7:0] kc [3] = '{8'h3b, 8'h2a, 8'h5b};
  logic [4:0] pt [7] = '{5'b10001, 5'b10110, 5'b11001, 5'b11000,
    5'b11100, 5'b11111, 5'b00100};
  assign {uart_f_irq_i, uart_e_irq_i, hw_monitor_irq_i, watchdog_timeout_i,
    uart_d_irq_i, ring_indicate_b_i, uart_c_irq_i, mouse_irq_i,
    keyboard_controller_irq_i, parallel_port_irq_i,
    floppy_controller_irq_i, uart_a_irq_i, uart_b_irq_i} = src;
  assign {gpio_event_c_i, gpio_event_b_i, gpio_event_a_i} = gp;
  pme_wake_event_control #(.LEVEL_CYCLES(LVL), .PULSE_CYCLES(PUL)) i_dut (.*);
  pme_host_model i_host (.clk_i(clk_i), .ps_n_i(power_switch_output_n_o),
    .cnt_o(p_cnt), .width_o(p_w));
  // ****
  // expectations
  // ****
  function automatic logic [7:0] rb(input logic [7:0] x, input logic [7:0] y);
    case (x)
      8'he7: rb = y & 8'hf9;
      8'hf2: rb = {7'h1f, y[0]};
      8'hf6: rb = y & 8'h7f;
      8'hf7: rb = y & 8'h3f;
      8'hfe: rb = y & 8'hf7;
      default: rb = 8'h00;
    endcase
  endfunction
  function automatic logic pl_on(input logic [4:0] c);
    pl_on = c[4] & (c[3:2] == 2'h1 | (c[3:2] == 2'h2 & c[0])
      | (c[3:2] == 2'h3 & !c[1]));
  endfunction
  // ****
  // bus and helpers
  // ****
  task automatic give_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bound(input int n);
    if (n >= 50) begin
      failures++;
      give_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] y,
    input logic [1:0] e = 2'h0);
    int n;
    @(posedge clk_i);
    awaddr_i <= {2'h0, x, 2'h0};
    wdata_i <= {24'h0, y};
    {awvalid_i, wvalid_i, bready_i} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    bready_i <= 1'b0;
    bound(n);
    `CHK(bresp_o, e)
  endtask
  task automatic ck(input logic [7:0] x, input logic [7:0] e,
    input logic [1:0] r = 2'h0);
    int n;
    @(posedge clk_i);
    araddr_i <= {2'h0, x, 2'h0};
    {arvalid_i, rready_i} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    rready_i <= 1'b0;
    rd_d = rdata_o[7:0];
    rd_r = rresp_o;
    bound(n);
    `CHK(rd_d, e)
    `CHK(rd_r, r)
  endtask
  task automatic send(input logic [7:0] c);
    @(posedge clk_i);
    kb_code_valid_i <= 1'b1;
    kb_code_i <= c;
    @(posedge clk_i);
    kb_code_valid_i <= 1'b0;
    tk(8);
  endtask
  task automatic wait_pulse(input int c, input logic e, input int w);
    int n;
    for (n = 0; n < w + 60 && p_cnt == c; n++) @(posedge clk_i);
    `CHK(p_cnt - c, e ? 1 : 0)
    if (e) `CHK(p_w >= w && p_w <= w + 2, 1'b1)
  endtask
  // ****
  // clock, timeout, sequence
  // ****
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #4000000;
    failures++;
    give_verdict;
  end
  initial begin
    nrst_i = 0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h0;
    {awaddr_i, araddr_i, wdata_i, wstrb_i} = {24'h0, 32'h0, 4'h1};
    {src, gp, kb_wake_enable_i, kb_code_valid_i, kb_code_i} = 26'h0;
    {power_loss_policy_i, last_state_off_i, prior_state_on_i} = 4'h0;
    {power_restored_i, bus_reset_input_n_i, power_good_i} = 3'h3;
    void'($urandom(32'h0cc50c86));
    tk(12);
    nrst_i <= 1'b1;
    foreach (ri[k]) ck(ri[k], ri[k] == 8'hf2 ? 8'h3e : 8'h00);
    ck(8'h10, 8'h00, 2'h2);
    wr(8'h10, 8'hff, 2'h2);
    for (i = 0; i < 20; i++) begin
      a = i < 5 ? wi[i] : wi[$urandom_range(4)];
      d = i < 5 ? 8'hff : 8'($urandom);
      wr(a, d);
      ck(a, rb(a, d));
      wr(a, 8'h00);
    end
    sl = 13'h0;
    for (i = 0; i < 12; i++) begin
      v = 13'($urandom);
      @(posedge clk_i);
      src <= v;
      @(posedge clk_i);
      src <= 13'h0;
      sl |= v;
      ck(8'hf3, {1'b0, sl[6:0]});
      ck(8'hf4, {2'h0, sl[12:7]});
      m = 16'($urandom);
      wr(8'hf3, m[7:0]);
      wr(8'hf4, m[15:8]);
      sl &= ~{m[13:8], m[6:0]};
    end
    wr(8'hf3, 8'hff);
    wr(8'hf4, 8'hff);
    wr(8'hf2, 8'h01);
    for (i = 0; i < 13; i++) begin
      a = i > 6 ? 8'hf7 : 8'hf6;
      m8 = 8'h01 << (i > 6 ? i - 7 : i);
      @(posedge clk_i);
      src <= 13'h1 << i;
      @(posedge clk_i);
      src <= 13'h0;
      tk(4);
      `CHK(pme_n_o, 1'b1)
      wr(a, m8);
      tk(4);
      `CHK(pme_n_o, 1'b0)
      wr(8'hf2, 8'h00);
      tk(4);
      `CHK(pme_n_o, 1'b1)
      wr(8'hf2, 8'h01);
      wr(a - 8'h03, m8);
      tk(4);
      `CHK(pme_n_o, 1'b1)
      wr(a, 8'h00);
    end
    for (i = 0; i < 3; i++) begin
      wr(8'hfe, 8'h01 << i);
      @(posedge clk_i);
      gp <= 3'h1 << i;
      tk(5);
      `CHK(pme_n_o, 1'b0)
      `CHK(power_switch_output_n_o, 1'b1)
      wr(8'hfe, 8'h10 << i);
      tk(5);
      `CHK(pme_n_o, 1'b1)
      `CHK(power_switch_output_n_o, 1'b0)
      gp <= 3'h0;
      wr(8'hfe, 8'h00);
    end
    kb_wake_enable_i <= 1'b1;
    wr(8'he1, 8'h30);
    wr(8'he2, 8'h2a);
    ck(8'he2, 8'h2a);
    wr(8'he1, 8'h40);
    wr(8'he2, 8'h3b);
    ck(8'he2, 8'h3b);
    for (i = 0; i < 6; i++) begin
      m8 = 8'h80 >> (i / 2);
      wr(8'he7, i[0] ? m8 : 8'he0 ^ m8);
      c0 = p_cnt;
      send(kc[i / 2]);
      wait_pulse(c0, i[0], PUL);
    end
    for (i = 0; i < 7; i++) begin
      pc = pt[i];
      wr(8'he7, {3'h0, pc[4], 4'h0});
      power_loss_policy_i <= pc[3:2];
      {last_state_off_i, prior_state_on_i} <= pc[1:0];
      c0 = p_cnt;
      tk(2);
      power_restored_i <= 1'b1;
      wait_pulse(c0, pl_on(pc), LVL);
      power_restored_i <= 1'b0;
    end
    for (i = 0; i < 2; i++) begin
      wr(8'he7, i[0] ? 8'h09 : 8'h00);
      bus_reset_input_n_i <= 1'b0;
      tk(6);
      `CHK(watchdog_reset_n_o, i[0])
      `CHK(hw_monitor_reset_n_o, !i[0])
      {bus_reset_input_n_i, power_good_i} <= 2'h2;
      tk(6);
      `CHK(watchdog_reset_n_o, !i[0])
      `CHK(hw_monitor_reset_n_o, i[0])
      bus_reset_input_n_i <= 1'b0;
      tk(6);
      {bus_reset_input_n_i, power_good_i} <= 2'h3;
      ck(8'he7, i[0] ? 8'h09 : 8'h00);
    end
    give_verdict;
  end
endmodule // pme_wake_event_control_tb
`default_nettype wire
